// ==== usae_regs.vh ====
// Register map, field positions, reset values and timing constants
// of the serial port engine.
// Assumes a 32-bit AXI4-Lite slave with a five-bit byte address.
`ifndef USAE_REGS_VH
`define USAE_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define USAE_OFS_BUFFER 4'h0
`define USAE_OFS_CONTROL 4'h4
`define USAE_OFS_POWER 4'h8
`define USAE_OFS_STATUS 4'hc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USAE_CTL_RI 0
`define USAE_CTL_TI 1
`define USAE_CTL_RB8 2
`define USAE_CTL_REN 4
`define USAE_CTL_MP 5
`define USAE_CTL_MODE 6
`define USAE_PWR_DBL 7
`define USAE_STA_TX 0
`define USAE_STA_RX 1
`define USAE_STA_REQ 2

// ----------------------------------------------------------------
// Reset values and response codes
// ----------------------------------------------------------------
`define USAE_CTL_RST 8'h00
`define USAE_PWR_RST 8'h00
`define USAE_RESP_OKAY 2'h0
`define USAE_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Machine-cycle phases: one aclk per phase, twelve per cycle
// ----------------------------------------------------------------
`define USAE_PH_S1P1 4'h0
`define USAE_PH_S3P1 4'h4
`define USAE_PH_S5P2 4'h9
`define USAE_PH_S6P2 4'hb
`define USAE_PH_LAST 4'hb

// ----------------------------------------------------------------
// Divide-by-16 counter and shift register preloads
// ----------------------------------------------------------------
`define USAE_CNT_LAST 4'hf
`define USAE_SAMP_FIRST 4'h6
`define USAE_SAMP_LAST 4'h8
`define USAE_RX0_INIT 9'h0fe
`define USAE_RX1_INIT 9'h1ff

`endif

// ==== usae_bit_detect.v ====
// Receive line synchroniser and three-sample majority bit detector.
// Assumes the data pin is asynchronous to aclk and the sample strobe
// comes from logic on aclk.
`timescale 1ns/1ns
`default_nettype none

module usae_bit_detect (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  input wire sample,
  output wire line_sync,
  output wire vote
);

  // ----------------------------------------------------------------
  // Two-flop synchroniser and sample taps
  // ----------------------------------------------------------------
  reg meta; // First stage, read only by the second stage.
  reg sync; // Second stage, safe for all other logic.
  reg [2:0] taps; // Last three samples taken inside a bit time.

  // The line idles high, so every stage resets to one to avoid a
  // false falling edge right after reset.
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b1;
      sync <= 1'b1;
      taps <= 3'h7;
    end else begin
      meta <= pin_in;
      sync <= meta;
      if (sample) begin
        taps <= {taps[1:0], sync};
      end
    end
  end

  assign line_sync = sync;

  // Two out of three wins, which rejects a single noisy sample.
  assign vote = (taps[0] & taps[1]) | (taps[0] & taps[2]) |
                (taps[1] & taps[2]);

endmodule // usae_bit_detect

`default_nettype wire

// ==== usae_core.v ====
// Serial port engine: mode 0 shift register link and mode 1 UART.
// Assumes an AXI4-Lite master on aclk and a timer overflow pulse
// from a timer that also runs on aclk.
//
// Function
// - Mode 0 moves eight bits LSB first.
// - Mode 0 write loads marker; send waits.
// - Send routes shifter and clock to pins.
// - Shift clock low S3-S5, high S6-S2.
// - Mode 0 transmit shifts right at S6P2.
// - Marker by MSB: last shift, done.
// - Mode 0 receive preloads 11111110, activates.
// - Mode 0 receive samples S5P2, shifts S6P2.
// - Zero reaches top: load buffer, set done.
// - Mode 1 frame: start, eight, stop.
// - Mode 1 rate comes from timer overflow.
// - Mode 1 transmit starts after counter rollover.
// - Start bit, then data, then shifts.
// - Mode 1 done at tenth rollover.
// - Falling edge resets counter, preloads 1FFH.
// - Majority of three samples per bit.
// - Nonzero start bit restarts edge search.
// - Nine-bit receive register, final shift.
// - Load only if flag clear, stop allowed.
// - Stop to ninth bit, byte to buffer.
// - Baud doubling bit resets to zero.
// - Undoubled rate halves the overflow rate.
// - Buffer write and read are separate.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "usae_regs.vh"

module usae_core (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [4:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire timer1_overflow,
  output reg shift_clock_pin,
  input wire sync_data_pin_in,
  output reg sync_data_pin_out,
  output reg sync_data_pin_oe
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Only the lower four words exist; the upper half is unmapped.
  function usae_mapped;
    input [4:0] addr;
    begin
      usae_mapped = ~addr[4];
    end
  endfunction

  // The first bit shifted in ends on top; this restores LSB order.
  function [7:0] usae_rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        usae_rev8[i] = v[7 - i];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [3:0] phase; // Machine-cycle phase, S1P1 is zero.
  reg half; // Halves the overflow rate when not doubled.
  reg [3:0] tx_cnt; // Transmit divide-by-16 counter.
  reg [3:0] rx_cnt; // Receive divide-by-16 counter.
  reg [8:0] tsr; // Transmit shift register with marker.
  reg tx_req; // A buffer write waits for its start point.
  reg tx_wait; // Start point found, waiting to raise send.
  reg send; // Transmit active.
  reg data_en; // Mode 1: shifter output drives the line.
  reg tx_fin; // Mode 0: last shift done, finish at S1P1.
  reg [8:0] rsr; // Receive shift register.
  reg rx0_arm; // Mode 0 receive start requested.
  reg rx0_go; // Mode 0 preload done, activate next phase.
  reg receive; // Mode 0 receive active.
  reg rx_fin; // Mode 0 last shift done, finish at S1P1.
  reg rx_busy; // Mode 1 frame in progress.
  reg rx_first; // Mode 1 first bit time of the frame.
  reg line_prev; // Previous synchronised line level.
  reg samp0; // Mode 0 data sampled at S5P2.
  reg [7:0] rx_buffer; // Receive side of the serial buffer.
  reg ri; // Receive done flag.
  reg ti; // Transmit done flag.
  reg rb8; // Received ninth bit.
  reg ren; // Receive enable.
  reg mp; // Multiprocessor bit.
  reg mode1; // Zero selects mode 0, one selects mode 1.
  reg dbl; // Baud doubling bit.
  reg aw_have; // Write address held.
  reg w_have; // Write data held.
  reg [4:0] aw_addr_q; // Held write address.
  reg [7:0] w_data_q; // Held low write byte.
  reg w_strb0; // Held strobe for the low byte.
  reg [31:0] rd_word; // Read mux output.

  wire line_sync; // Synchronised data pin.
  wire vote; // Majority of the last three samples.

  // ----------------------------------------------------------------
  // Rate and strobe terms
  // ----------------------------------------------------------------

  // One sixteenth-bit tick per overflow when doubled, else every
  // second overflow.
  wire tick16 = timer1_overflow & (dbl | half);
  wire tx_roll = tick16 && (tx_cnt == `USAE_CNT_LAST);
  wire rx_roll = tick16 && (rx_cnt == `USAE_CNT_LAST);
  wire samp_win = tick16 && rx_busy && mode1 &&
                  (rx_cnt >= `USAE_SAMP_FIRST) &&
                  (rx_cnt <= `USAE_SAMP_LAST);
  // Shift clock is low in S3, S4 and S5, high elsewhere.
  wire sclk_wave = !((phase >= `USAE_PH_S3P1) &&
                     (phase <= `USAE_PH_S5P2));
  wire s6p2 = (phase == `USAE_PH_S6P2);
  wire s1p1 = (phase == `USAE_PH_S1P1);
  // The marker sits just left of the data MSB.
  wire tx_last = (tsr[8:2] == 7'h00) && tsr[1];
  wire wr_go = aw_have && w_have && !bvalid;
  wire wr_ok = wr_go && usae_mapped(aw_addr_q) && w_strb0;
  wire wr_buf = wr_ok && (aw_addr_q[3:0] == `USAE_OFS_BUFFER);
  wire wr_ctl = wr_ok && (aw_addr_q[3:0] == `USAE_OFS_CONTROL);
  wire wr_pwr = wr_ok && (aw_addr_q[3:0] == `USAE_OFS_POWER);

  // ----------------------------------------------------------------
  // Receive line detector
  // ----------------------------------------------------------------
  usae_bit_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(sync_data_pin_in),
    .sample(samp_win),
    .line_sync(line_sync),
    .vote(vote)
  );

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------

  // One process holds every flag so that a hardware set, written
  // after the software write below, always beats a clear.
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 4'h0;
      half <= 1'b0;
      tx_cnt <= 4'h0;
      rx_cnt <= 4'h0;
      tsr <= 9'h000;
      tx_req <= 1'b0;
      tx_wait <= 1'b0;
      send <= 1'b0;
      data_en <= 1'b0;
      tx_fin <= 1'b0;
      rsr <= 9'h000;
      rx0_arm <= 1'b0;
      rx0_go <= 1'b0;
      receive <= 1'b0;
      rx_fin <= 1'b0;
      rx_busy <= 1'b0;
      rx_first <= 1'b0;
      line_prev <= 1'b1;
      samp0 <= 1'b1;
      rx_buffer <= 8'h00;
      ri <= 1'b0;
      ti <= 1'b0;
      rb8 <= 1'b0;
      ren <= 1'b0;
      mp <= 1'b0;
      mode1 <= 1'b0;
      dbl <= 1'b0;
      shift_clock_pin <= 1'b1;
      sync_data_pin_out <= 1'b1;
      sync_data_pin_oe <= 1'b0;
    end else begin
      // Phase counter and rate dividers.
      if (phase == `USAE_PH_LAST) begin
        phase <= 4'h0;
      end else begin
        phase <= phase + 4'h1;
      end
      if (timer1_overflow) begin
        half <= ~half;
      end
      if (tick16) begin
        tx_cnt <= tx_cnt + 4'h1;
      end
      line_prev <= line_sync;

      // Software writes to control and power registers.
      if (wr_ctl) begin
        ri <= w_data_q[`USAE_CTL_RI];
        ti <= w_data_q[`USAE_CTL_TI];
        rb8 <= w_data_q[`USAE_CTL_RB8];
        ren <= w_data_q[`USAE_CTL_REN];
        mp <= w_data_q[`USAE_CTL_MP];
        mode1 <= w_data_q[`USAE_CTL_MODE];
      end
      if (wr_pwr) begin
        dbl <= w_data_q[`USAE_PWR_DBL];
      end

      if (!mode1) begin
        // Mode 0 transmit: the request is taken at S6P2 and send
        // rises one machine cycle later.
        if (s6p2 && tx_req) begin
          tx_req <= 1'b0;
          tx_wait <= 1'b1;
        end
        if (s6p2 && tx_wait) begin
          tx_wait <= 1'b0;
          send <= 1'b1;
        end
        if (s6p2 && send) begin
          tsr <= {1'b0, tsr[8:1]};
          if (tx_last) begin
            tx_fin <= 1'b1;
          end
        end
        if (s1p1 && tx_fin) begin
          tx_fin <= 1'b0;
          send <= 1'b0;
          ti <= 1'b1;
        end

        // Mode 0 receive: armed in one cycle, preloaded at the
        // next S6P2, active one phase later.
        if (s1p1 && ren && !ri && !receive && !rx0_go && !rx_fin) begin
          rx0_arm <= 1'b1;
        end
        if (s6p2 && rx0_arm) begin
          rx0_arm <= 1'b0;
          rsr <= `USAE_RX0_INIT;
          rx0_go <= 1'b1;
        end
        if (rx0_go) begin
          rx0_go <= 1'b0;
          receive <= 1'b1;
        end
        if (phase == `USAE_PH_S5P2) begin
          samp0 <= line_sync;
        end
        if (s6p2 && receive) begin
          rsr <= {rsr[7:0], samp0};
          if (!rsr[7]) begin
            rx_buffer <= usae_rev8({rsr[6:0], samp0});
            rx_fin <= 1'b1;
          end
        end
        if (s1p1 && rx_fin) begin
          rx_fin <= 1'b0;
          receive <= 1'b0;
          ri <= 1'b1;
        end
      end else begin
        // Mode 1 transmit: bit times follow the counter, not the
        // write, so a write just after a rollover waits a bit time.
        if (tx_roll && tx_req) begin
          tx_req <= 1'b0;
          tx_wait <= 1'b1;
        end
        if (s1p1 && tx_wait) begin
          tx_wait <= 1'b0;
          send <= 1'b1;
          data_en <= 1'b0;
        end
        if (tx_roll && send) begin
          if (!data_en) begin
            data_en <= 1'b1;
          end else begin
            tsr <= {1'b0, tsr[8:1]};
            if (tx_last) begin
              send <= 1'b0;
              data_en <= 1'b0;
              ti <= 1'b1;
            end
          end
        end

        // Mode 1 receive: edge search, then one shift per bit.
        if (!rx_busy) begin
          if (ren && line_prev && !line_sync) begin
            rx_busy <= 1'b1;
            rx_first <= 1'b1;
            rx_cnt <= 4'h0;
            rsr <= `USAE_RX1_INIT;
          end
        end else begin
          if (tick16) begin
            rx_cnt <= rx_cnt + 4'h1;
          end
          if (rx_roll) begin
            if (rx_first && vote) begin
              rx_busy <= 1'b0;
            end else begin
              rx_first <= 1'b0;
              rsr <= {rsr[7:0], vote};
              if (!rsr[8]) begin
                // Final shift: the stop bit is the vote just taken.
                rx_busy <= 1'b0;
                if (!ri && (!mp || vote)) begin
                  rx_buffer <= usae_rev8(rsr[7:0]);
                  rb8 <= vote;
                  ri <= 1'b1;
                end
              end
            end
          end
        end
      end

      // A buffer write comes last so a request consumed this cycle
      // never swallows a fresh one.
      if (wr_buf) begin
        tsr <= {1'b1, w_data_q};
        tx_req <= 1'b1;
      end

      // Pin drivers: mode 0 clock and data, mode 1 serial line.
      if (mode1) begin
        if (send) begin
          shift_clock_pin <= data_en ? tsr[0] : 1'b0;
        end else begin
          shift_clock_pin <= 1'b1;
        end
      end else begin
        shift_clock_pin <= (send || receive) ? sclk_wave : 1'b1;
      end
      sync_data_pin_out <= tsr[0];
      sync_data_pin_oe <= !mode1 && send;
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------

  // Reading the buffer returns only the receive side.
  always @* begin
    rd_word = 32'h0000_0000;
    case (araddr[3:0])
      `USAE_OFS_BUFFER: begin
        rd_word[7:0] = rx_buffer;
      end
      `USAE_OFS_CONTROL: begin
        rd_word[`USAE_CTL_RI] = ri;
        rd_word[`USAE_CTL_TI] = ti;
        rd_word[`USAE_CTL_RB8] = rb8;
        rd_word[`USAE_CTL_REN] = ren;
        rd_word[`USAE_CTL_MP] = mp;
        rd_word[`USAE_CTL_MODE] = mode1;
      end
      `USAE_OFS_POWER: begin
        rd_word[`USAE_PWR_DBL] = dbl;
      end
      `USAE_OFS_STATUS: begin
        rd_word[`USAE_STA_TX] = send;
        rd_word[`USAE_STA_RX] = receive | rx_busy;
        rd_word[`USAE_STA_REQ] = tx_req | tx_wait;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
    if (!usae_mapped(araddr)) begin
      rd_word = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------

  // Ready stays low from handshake to response: one write, one read.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `USAE_RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `USAE_RESP_OKAY;
      rdata <= 32'h0000_0000;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q <= 8'h00;
      w_strb0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_have <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_have <= 1'b1;
        w_data_q <= wdata[7:0];
        w_strb0 <= wstrb[0];
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        bvalid <= 1'b1;
        bresp <= usae_mapped(aw_addr_q) ? `USAE_RESP_OKAY :
                                          `USAE_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= usae_mapped(araddr) ? `USAE_RESP_OKAY :
                                       `USAE_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // usae_core

`default_nettype wire

// ==== usae_asserts.sv ====
// Checker for the serial engine: bus answers and shift pin timing.
// Assumes a bind to usae_core; it sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "usae_regs.vh"

module usae_asserts (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [4:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire shift_clock_pin,
  input wire sync_data_pin_out,
  input wire sync_data_pin_oe
);
  reg [7:0] oe_len; // Cycles the data pin has been driven so far.

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Counts drive cycles, so a whole send is judged by its length.
  always @(posedge aclk) begin
    if (!aresetn || !sync_data_pin_oe) oe_len <= 8'h00;
    else oe_len <= oe_len + 8'h01;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  clk_low_six_a: assert property ($fell(shift_clock_pin) &&
    sync_data_pin_oe |-> !shift_clock_pin [*6] ##1 shift_clock_pin)
    else $error("shift clock low span wrong");
  clk_high_six_a: assert property ($rose(shift_clock_pin) |->
    shift_clock_pin [*6]) else $error("shift clock high span short");
  data_still_a: assert property (sync_data_pin_oe &&
    !shift_clock_pin |-> $stable(sync_data_pin_out))
    else $error("data moved while shift clock low");
  send_span_a: assert property ($fell(sync_data_pin_oe) |->
    oe_len >= 8'h5f && oe_len <= 8'h63) else $error("send length wrong");
  wr_answer_a: assert property (awvalid && awready && wvalid &&
    wready |-> ##2 bvalid) else $error("write answer late");
  wr_release_a: assert property (bvalid && bready |=> !bvalid &&
    awready && wready) else $error("write not released");
  rd_answer_a: assert property (arvalid && arready |=> rvalid &&
    !arready) else $error("read answer late");
  rd_release_a: assert property (rvalid && rready |=> !rvalid &&
    arready) else $error("read not released");
  unmapped_rd_a: assert property (arvalid && arready && araddr[4] |=>
    rresp == `USAE_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");

  send_done_c: cover property ($fell(sync_data_pin_oe));
  listen_clk_c: cover property ($fell(shift_clock_pin) &&
    !sync_data_pin_oe);
  refused_c: cover property (rvalid && rresp == `USAE_RESP_SLVERR);
endmodule // usae_asserts
`default_nettype wire

// ==== usae_far_node.sv ====
// Far side model: shift register for mode 0, serial node for mode 1.
// Assumes the bench resolves the data pin and sets the mode input.
`timescale 1ns/1ns
`default_nettype none

module usae_far_node (
  input wire aclk,
  input wire mode1,
  input wire sclk,
  input wire data_oe,
  input wire data_pin,
  output reg line
);
  reg [7:0] m0_tx = 8'h00; // Bits served to the engine, LSB first.
  reg [7:0] m0_rx = 8'h00; // Bits taken from the engine.
  reg sclk_d = 1'b1; // Last shift clock level, for edge detection.
  initial line = 1'b1;

  // Serves a bit on each falling clock edge while the engine listens,
  // takes one on each rising edge while it drives.
  always @(posedge aclk) begin
    sclk_d <= sclk;
    if (!mode1 && !data_oe && sclk_d && !sclk) begin
      line <= m0_tx[0];
      // Spent bits return inverted, so extra samples show up as errors.
      m0_tx <= {~m0_tx[0], m0_tx[7:1]};
    end
    if (!mode1 && data_oe && !sclk_d && sclk) m0_rx <= {data_pin, m0_rx[7:1]};
  end

  task m0_load(input [7:0] v);
    m0_tx = v;
  endtask

  // Holds the line at v for n clocks.
  task hold(input v, input integer n);
    begin
      @(posedge aclk);
      line <= v;
      repeat (n - 1) @(posedge aclk);
    end
  endtask

  // Sends ten bits LSB first, then idles high.
  task send_frame(input [9:0] f, input integer bitc);
    integer k;
    begin
      for (k = 0; k < 10; k = k + 1) hold(f[k], bitc);
      hold(1'b1, 2);
    end
  endtask

  // Waits for a start edge, samples ten bit middles.
  task get_frame(input integer bitc, output [9:0] f);
    integer k;
    begin
      f = 10'h000;
      for (k = 0; k < 4000 && sclk; k = k + 1) @(posedge aclk);
      repeat (bitc / 2) @(posedge aclk);
      for (k = 0; k < 10; k = k + 1) begin
        f[k] = sclk;
        repeat (bitc) @(posedge aclk);
      end
    end
  endtask
endmodule // usae_far_node
`default_nettype wire

// ==== usae_core_tb.sv ====
// Bench for the serial engine: bus tasks, scenarios and verdict.
// Assumes usae_core, its register header and the far side model.
`timescale 1ns/1ns
`default_nettype none
`include "usae_regs.vh"

module usae_core_tb;
  localparam [4:0] A_BUF = {1'b0, `USAE_OFS_BUFFER}; // Serial buffer.
  localparam [4:0] A_CTL = {1'b0, `USAE_OFS_CONTROL}; // Control.
  localparam [4:0] A_PWR = {1'b0, `USAE_OFS_POWER}; // Power control.
  localparam [4:0] A_STA = {1'b0, `USAE_OFS_STATUS}; // Status.
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [4:0] awaddr = 5'h00;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'h0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg [4:0] araddr = 5'h00;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg timer1_overflow = 1'b0;
  reg [1:0] tdiv = 2'h0; // Overflow every 4 clocks: 64 or 128 per bit.
  reg m1 = 1'b0; // Far side follows the asynchronous mode.
  wire awready, wready, bvalid, arready, rvalid, far_line, pin;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire shift_clock_pin, sync_data_pin_out, sync_data_pin_oe;
  integer err_count = 0;
  integer compares = 0;
  reg [31:0] d;
  reg [1:0] r;
  reg [9:0] f;

  // The engine owns the data wire only while it drives it.
  assign pin = sync_data_pin_oe ? sync_data_pin_out : far_line;

  usae_core dut (.*, .sync_data_pin_in(pin));

  usae_far_node far (.aclk(aclk), .mode1(m1), .sclk(shift_clock_pin),
    .data_oe(sync_data_pin_oe), .data_pin(pin), .line(far_line));

  initial forever #5 aclk = ~aclk;

  // Timer stand-in: a one-clock overflow pulse every fourth clock.
  always @(posedge aclk) begin
    tdiv <= tdiv + 2'h1;
    timer1_overflow <= (tdiv == 2'h3);
  end

  // ------------------------------------------------------------
  // Bus tasks and comparisons
  // ------------------------------------------------------------
  task bad(input [8*16-1:0] msg);
    begin
      err_count = err_count + 1;
      $display("mismatch at %0t: %0s", $time, msg);
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) bad("value differs");
    end
  endtask

  task chk_resp(input [1:0] got, input [1:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) bad("response differs");
    end
  endtask

  // Address and data go out together; each drops once it is taken.
  task wr(input [4:0] a, input [7:0] v, output [1:0] rs);
    integer n;
    reg g;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, v};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      g = 1'b0;
      for (n = 0; n < 64 && !g; n = n + 1) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        g = bvalid && bready;
        rs = bresp;
        bready <= !g;
      end
      if (!g) bad("write timeout");
    end
  endtask

  task rd(input [4:0] a, output [31:0] v, output [1:0] rs);
    integer n;
    reg g;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      g = 1'b0;
      for (n = 0; n < 64 && !g; n = n + 1) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        g = rvalid && rready;
        v = rdata;
        rs = rresp;
        rready <= !g;
      end
      if (!g) bad("read timeout");
    end
  endtask

  // Polls control until the given flag reads one; d keeps the value.
  task wait_ctl(input integer b);
    integer n;
    begin
      d = 32'h0;
      for (n = 0; n < 1000 && d[b] !== 1'b1; n = n + 1) rd(A_CTL, d, r);
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    begin
      rd(A_CTL, d, r);
      chk(d, {24'h0, `USAE_CTL_RST});
      rd(A_PWR, d, r);
      chk(d, {24'h0, `USAE_PWR_RST});
      rd(A_STA, d, r);
      chk(d, 32'h0);
      rd(5'h10, d, r);
      chk_resp(r, `USAE_RESP_SLVERR);
      wr(5'h14, 8'h5a, r);
      chk_resp(r, `USAE_RESP_SLVERR);
    end
  endtask

  task t_m0;
    begin
      wr(A_BUF, 8'ha5, r);
      chk_resp(r, `USAE_RESP_OKAY);
      wait_ctl(`USAE_CTL_TI);
      chk(d, 32'h02);
      chk({24'h0, far.m0_rx}, 32'ha5);
      rd(A_STA, d, r);
      chk(d, 32'h0);
      far.m0_load(8'h3c);
      wr(A_CTL, 8'h10, r);
      wait_ctl(`USAE_CTL_RI);
      chk(d, 32'h11);
      // The buffer reads the received byte, not the one sent before.
      rd(A_BUF, d, r);
      chk(d, 32'h3c);
      wr(A_CTL, 8'h00, r);
    end
  endtask

  // Undoubled rate: the far side expects 128 clocks a bit.
  task t_m1_tx;
    begin
      m1 <= 1'b1;
      wr(A_CTL, 8'h40, r);
      fork
        far.get_frame(128, f);
        wr(A_BUF, 8'h96, r);
      join
      chk({22'h0, f}, {22'h0, 1'b1, 8'h96, 1'b0});
      wait_ctl(`USAE_CTL_TI);
      chk(d, 32'h42);
    end
  endtask

  // Doubled rate, 64 clocks a bit: false start, load, refused loads.
  task t_m1_rx;
    begin
      wr(A_PWR, 8'h80, r);
      wr(A_CTL, 8'h50, r);
      far.hold(1'b1, 40);
      far.hold(1'b0, 3);
      far.hold(1'b1, 100);
      rd(A_CTL, d, r);
      chk(d, 32'h50);
      far.send_frame({1'b1, 8'h5a, 1'b0}, 64);
      wait_ctl(`USAE_CTL_RI);
      chk(d, 32'h55);
      rd(A_BUF, d, r);
      chk(d, 32'h5a);
      far.send_frame({1'b1, 8'h11, 1'b0}, 64);
      far.hold(1'b1, 100);
      rd(A_BUF, d, r);
      chk(d, 32'h5a);
      wr(A_CTL, 8'h70, r);
      far.send_frame({1'b0, 8'h22, 1'b0}, 64);
      far.hold(1'b1, 100);
      rd(A_CTL, d, r);
      chk(d, 32'h70);
      far.send_frame({1'b1, 8'h33, 1'b0}, 64);
      wait_ctl(`USAE_CTL_RI);
      chk(d, 32'h75);
      rd(A_BUF, d, r);
      chk(d, 32'h33);
    end
  endtask

  task complete_run;
    begin
      $display("errors %0d in %0d compares", err_count, compares);
      if (err_count == 0 && compares > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_m0;
    t_m1_tx;
    t_m1_rx;
    complete_run;
  end

  // Hang guard: the run needs about 5000 clocks.
  initial begin
    #400000;
    bad("watchdog");
    complete_run;
  end
endmodule // usae_core_tb

bind usae_core usae_asserts chk_i (.*);
`default_nettype wire
